// File: design/adcc_defs.svh
// constants for the converter calibration and mode control block
// Contract
// R1 - output equals (filter sample minus offset word) times gain word over 400000h
// R2 - corrected result is limited to a 24-bit value
// R3 - offset word is 24-bit two's complement, zero means no correction
// R4 - global chop mode ignores the offset word
// R5 - gain word is 24-bit unsigned, 400000h is unity gain
// R6 - calibrations average 1, 4, 8 or 16 readings per the average count field
// R7 - self offset calibration selects monitor input 001, then measures offset
// R8 - host applies null input; offset calibrations write the offset word
// R9 - after a calibration a new conversion starts and ready falls at its end
// R10 - host applies full scale; gain calibration writes the averaged gain word
// R11 - calibration commands are not executed in standby
// R12 - host calibrates offset before gain and waits for settled supplies
// R13 - any reset source resets the device at once in any mode
// R14 - sleep command aborts conversion and enters power-down directly
// R15 - start pin rising edge or start command restarts conversion at once
// R16 - reset restores register defaults, enters standby, waits for start
// R17 - reset returns clock source selection to the internal oscillator
// R18 - power-on reset completion sets the power-on flag
// R19 - host waits 2.2 ms after power-up, except for polling not-ready
// R20 - host polls not-ready at half the maximum serial clock rate
// R21 - not-ready flag clears once internal configuration completes
// R22 - conversion mode bit selects continuous or single-shot
// R23 - mode bit 0 is continuous, 1 is single-shot
// R24 - not-ready flag is bit 6 of the status byte
// R25 - overflow saturates to 7FFFFFh or 800000h, never wraps
// R26 - ready stays high and no data is shown during calibration averaging
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

// register selects on the register port
`define ADCC_SEL_OFFSET 2'h0
`define ADCC_SEL_GAIN 2'h1
`define ADCC_SEL_CTRL 2'h2
`define ADCC_SEL_STATUS 2'h3

// control register fields
`define ADCC_CTRL_W 5
`define ADCC_CTRL_MODE 0
`define ADCC_CTRL_CHOP 1
`define ADCC_CTRL_AVG_LO 2
`define ADCC_CTRL_AVG_HI 3
`define ADCC_CTRL_EXTCLK 4
`define ADCC_CTRL_RESET 5'h00

// status byte fields
`define ADCC_STAT_POR 7
`define ADCC_STAT_NRDY 6

// data words
`define ADCC_OFFSET_RESET 24'h00_0000
`define ADCC_GAIN_UNITY 24'h40_0000
`define ADCC_GAIN_SHIFT 22
`define ADCC_GAIN_MAX 24'hFF_FFFF
`define ADCC_POS_FULL 24'h7F_FFFF
`define ADCC_NEG_FULL 24'h80_0000

// monitor input selections
`define ADCC_MON_NORMAL 3'h0
`define ADCC_MON_MIDSCALE 3'h1

// averaging shifts for 1, 4, 8, 16 readings
`define ADCC_AVG_SHIFT_1 3'h0
`define ADCC_AVG_SHIFT_4 3'h2
`define ADCC_AVG_SHIFT_8 3'h3
`define ADCC_AVG_SHIFT_16 3'h4

// gain division steps (numerator bits)
`define ADCC_DIV_STEPS 6'h2E

// timing
`define ADCC_POR_TIME_NS 2_200_000
`define ADCC_CLK_PERIOD_NS 20

`endif

// File: design/adcc_pkg.sv
// types and shared arithmetic for the converter calibration and mode control block
`include "adcc_defs.svh"

package adcc_pkg;

	// operating states
	typedef enum logic [2:0] {
		ST_CONFIG,
		ST_STANDBY,
		ST_CONVERT,
		ST_CALIB,
		ST_DIVIDE,
		ST_SLEEP
	} adcc_state_t;

	// calibration kinds
	typedef enum logic [1:0] {
		CAL_SELF_OFS,
		CAL_SYS_OFS,
		CAL_SYS_GAIN
	} adcc_cal_t;

	// clip a wide signed value to 24 bits, never wrapping
	function automatic logic [23:0] adcc_sat24(input logic signed [49:0] v);
		logic signed [49:0] hi;
		logic signed [49:0] lo;
		hi = 50'sd8388607;
		lo = -50'sd8388608;
		if (v > hi)
			return `ADCC_POS_FULL;
		else if (v < lo)
			return `ADCC_NEG_FULL;
		else
			return v[23:0];
	endfunction

	// averaging count field to right shift
	function automatic logic [2:0] adcc_avg_shift(input logic [1:0] sel);
		case (sel)
			2'h0: return `ADCC_AVG_SHIFT_1;
			2'h1: return `ADCC_AVG_SHIFT_4;
			2'h2: return `ADCC_AVG_SHIFT_8;
			default: return `ADCC_AVG_SHIFT_16;
		endcase
	endfunction

endpackage

// File: design/adcc_corrector.sv
// offset and gain correction datapath with saturation
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.svh"

module adcc_corrector
	import adcc_pkg::*;
(
	// filter sample
	input wire logic [23:0] raw_i,
	// correction words
	input wire logic [23:0] offset_i,
	input wire logic [23:0] gain_i,
	input wire logic chop_i,
	// results
	output logic [23:0] diff_o,
	output logic [23:0] corr_o
);

	logic signed [49:0] diff_w;
	logic signed [49:0] prod_w;
	logic signed [49:0] scaled_w;
	logic signed [49:0] ofs_w;

	// chop mode drops the offset word entirely
	assign ofs_w = chop_i ? 50'sd0 : 50'(signed'(offset_i)); // [R4] [R3]
	assign diff_w = 50'(signed'(raw_i)) - ofs_w; // [R1]
	// gain word is unsigned, so widen with a zero
	assign prod_w = diff_w * $signed({26'h000_0000, gain_i}); // [R5] [R1]
	assign scaled_w = prod_w >>> `ADCC_GAIN_SHIFT; // [R1]
	// both paths clip rather than wrap
	assign diff_o = adcc_sat24(diff_w); // [R25]
	assign corr_o = adcc_sat24(scaled_w); // [R2] [R25]

endmodule // adcc_corrector
`default_nettype wire

// File: design/adcc_control.sv
// operating mode, calibration and correction control of the converter
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.svh"

module adcc_control
	import adcc_pkg::*;
#(
	parameter int unsigned POR_CYCLES = `ADCC_POR_TIME_NS / `ADCC_CLK_PERIOD_NS
)
(
	// clock, reset, enable
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	// device pins
	input wire logic start_sync_i,
	input wire logic pin_reset_n_i,
	// decoded commands, one-cycle pulses
	input wire logic cmd_start_i,
	input wire logic cmd_stop_i,
	input wire logic cmd_sleep_i,
	input wire logic cmd_wake_i,
	input wire logic cmd_reset_i,
	input wire logic cmd_self_ofs_cal_i,
	input wire logic cmd_sys_ofs_cal_i,
	input wire logic cmd_sys_gain_cal_i,
	input wire logic data_read_i,
	input wire logic status_clear_i,
	// register port
	input wire logic reg_wr_i,
	input wire logic [1:0] reg_sel_i,
	input wire logic [23:0] reg_wdata_i,
	output logic [23:0] reg_rdata_o,
	// digital filter
	input wire logic filt_valid_i,
	input wire logic [23:0] filt_data_i,
	output logic conv_restart_o,
	output logic conv_run_o,
	// analog and clock controls
	output logic [2:0] monitor_input_select_o,
	output logic ext_clock_sel_o,
	output logic powered_down_o,
	// results
	output logic [23:0] result_o,
	output logic result_ready_n_o,
	output logic [7:0] status_o
);

	localparam int CW = $clog2(POR_CYCLES + 1);

	////////////////////////////////////////////////////////////////////////
	// declarations

	adcc_state_t state_q, state_d;
	adcc_cal_t cal_kind_q;
	logic start_s1_q, start_s2_q, start_s3_q;
	logic prst_s1_q, prst_s2_q;
	logic [CW-1:0] cfg_cnt_q;
	logic por_pending_q, power_on_flag_q;
	logic [23:0] offset_q, gain_q;
	logic [`ADCC_CTRL_W-1:0] ctrl_q;
	logic stop_pending_q;
	logic signed [27:0] acc_q;
	logic [4:0] cal_cnt_q;
	logic [45:0] div_num_q;
	logic [23:0] div_rem_q, div_den_q, div_quot_q;
	logic div_ovf_q;
	logic [5:0] div_cnt_q;
	logic [23:0] result_q, reg_rdata_q;
	logic ready_n_q, restart_q;
	logic [23:0] diff_w, corr_w;

	////////////////////////////////////////////////////////////////////////
	// decoded events

	wire soft_rst = cmd_reset_i | ~prst_s2_q; // [R13]
	wire pin_rise = start_s2_q & ~start_s3_q; // [R15]
	wire start_evt = pin_rise | cmd_start_i; // [R15]
	wire stop_evt = cmd_stop_i | (start_s3_q & ~start_s2_q);
	wire cfg_done = (state_q == ST_CONFIG) && (cfg_cnt_q == CW'(POR_CYCLES));
	wire single_shot = ctrl_q[`ADCC_CTRL_MODE]; // [R22] [R23]
	wire [1:0] avg_sel = ctrl_q[`ADCC_CTRL_AVG_HI:`ADCC_CTRL_AVG_LO];
	wire [2:0] avg_sh = adcc_avg_shift(avg_sel); // [R6]
	wire [4:0] avg_last = 5'((5'h01 << avg_sh) - 5'h01); // [R6]
	// calibration only from a running conversion, never from standby
	wire cal_cmd = cmd_self_ofs_cal_i | cmd_sys_ofs_cal_i | cmd_sys_gain_cal_i;
	wire cal_ok = (state_q == ST_CONVERT) && !stop_pending_q && cal_cmd; // [R11]
	wire in_cal = (state_q == ST_CALIB);
	wire cal_sample = in_cal && filt_valid_i && !start_evt;
	wire cal_last = cal_sample && (cal_cnt_q == avg_last); // [R6]
	wire is_gain_cal = (cal_kind_q == CAL_SYS_GAIN);
	wire [23:0] cal_src = is_gain_cal ? diff_w : filt_data_i; // [R10] [R8]
	wire signed [27:0] acc_next = acc_q + 28'(signed'(cal_src));
	wire [23:0] cal_avg = 24'(acc_next >>> avg_sh); // [R6]
	wire conv_done = (state_q == ST_CONVERT) && filt_valid_i && !start_evt;
	wire div_last = (state_q == ST_DIVIDE) && !start_evt &&
		(div_cnt_q == `ADCC_DIV_STEPS - 6'h01); // start aborts, no gain update
	wire [24:0] div_trial = {div_rem_q, div_num_q[45]};
	wire div_ge = div_trial >= {1'b0, div_den_q};
	wire [24:0] div_sub = div_trial - {1'b0, div_den_q};
	wire [23:0] div_rem_n = div_ge ? div_sub[23:0] : div_trial[23:0];
	wire [23:0] gain_new = (div_ovf_q | div_quot_q[23]) ? `ADCC_GAIN_MAX :
		{div_quot_q[22:0], div_ge}; // [R10]
	wire wr_ok = reg_wr_i && (state_q != ST_CONFIG);

	////////////////////////////////////////////////////////////////////////
	// correction datapath

	adcc_corrector u_corr (
		.raw_i(filt_data_i),
		.offset_i(offset_q),
		.gain_i(gain_q),
		.chop_i(ctrl_q[`ADCC_CTRL_CHOP]),
		.diff_o(diff_w),
		.corr_o(corr_w)
	);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers, held still by the clock enable

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			{start_s1_q, start_s2_q, start_s3_q} <= 3'h0;
			{prst_s1_q, prst_s2_q} <= 2'h3;
		end
		else if (ce_i)
		begin
			{start_s1_q, start_s2_q, start_s3_q} <= {start_sync_i, start_s1_q, start_s2_q};
			{prst_s1_q, prst_s2_q} <= {pin_reset_n_i, prst_s1_q};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state; reset overrides everything else, sleep overrides everything outside ST_CONFIG

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_CONFIG: if (cfg_done) state_d = ST_STANDBY; // [R16]
			ST_STANDBY: if (start_evt) state_d = ST_CONVERT; // [R16]
			ST_CONVERT:
			begin
				if (start_evt)
					state_d = ST_CONVERT; // [R15]
				else if (cal_ok)
					state_d = ST_CALIB;
				else if (conv_done && (single_shot || stop_pending_q))
					state_d = ST_STANDBY; // [R22] [R23]
			end
			ST_CALIB:
			begin
				if (start_evt)
					state_d = ST_CONVERT; // [R15]
				else if (cal_last)
					state_d = is_gain_cal ? ST_DIVIDE : ST_CONVERT; // [R9]
			end
			ST_DIVIDE: if (start_evt || div_last) state_d = ST_CONVERT; // [R15] [R9]
			ST_SLEEP: if (cmd_wake_i) state_d = ST_STANDBY;
			default: state_d = ST_STANDBY;
		endcase
		if (cmd_sleep_i && state_q != ST_CONFIG)
			state_d = ST_SLEEP; // [R14]
	end

	// state, configuration counter and power-on bookkeeping
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			state_q <= ST_CONFIG;
			cfg_cnt_q <= '0;
			por_pending_q <= 1'b1;
		end
		else if (ce_i)
		begin
			if (soft_rst)
			begin
				state_q <= ST_CONFIG; // [R13]
				cfg_cnt_q <= '0;
			end
			else
			begin
				state_q <= state_d;
				if (state_q == ST_CONFIG && !cfg_done)
					cfg_cnt_q <= CW'(cfg_cnt_q + 1'b1);
				if (cfg_done)
					por_pending_q <= 1'b0;
			end
		end
	end

	// power-on flag: hardware set wins over a same-cycle clear
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
			power_on_flag_q <= 1'b0;
		else if (ce_i)
		begin
			if (cfg_done && por_pending_q && !soft_rst)
				power_on_flag_q <= 1'b1; // [R18]
			else if (status_clear_i)
				power_on_flag_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers; calibration results win over host writes

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			offset_q <= `ADCC_OFFSET_RESET;
			gain_q <= `ADCC_GAIN_UNITY;
			ctrl_q <= `ADCC_CTRL_RESET;
		end
		else if (ce_i)
		begin
			if (soft_rst)
			begin
				offset_q <= `ADCC_OFFSET_RESET; // [R16]
				gain_q <= `ADCC_GAIN_UNITY;
				ctrl_q <= `ADCC_CTRL_RESET; // [R17]
			end
			else if (cal_last && !is_gain_cal)
				offset_q <= cal_avg; // [R8]
			else if (div_last)
				gain_q <= gain_new; // [R10]
			else if (wr_ok)
			begin
				if (reg_sel_i == `ADCC_SEL_OFFSET)
					offset_q <= reg_wdata_i;
				if (reg_sel_i == `ADCC_SEL_GAIN)
					gain_q <= reg_wdata_i;
				if (reg_sel_i == `ADCC_SEL_CTRL)
					ctrl_q <= reg_wdata_i[`ADCC_CTRL_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// calibration bookkeeping and averaging accumulator

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			cal_kind_q <= CAL_SELF_OFS;
			acc_q <= '0;
			cal_cnt_q <= '0;
			stop_pending_q <= 1'b0;
		end
		else if (ce_i)
		begin
			if (cal_ok)
			begin
				cal_kind_q <= cmd_self_ofs_cal_i ? CAL_SELF_OFS :
					cmd_sys_ofs_cal_i ? CAL_SYS_OFS : CAL_SYS_GAIN;
				acc_q <= '0;
				cal_cnt_q <= '0;
			end
			else if (cal_sample)
			begin
				acc_q <= acc_next; // [R6]
				cal_cnt_q <= 5'(cal_cnt_q + 5'h01);
			end
			// a stop only lets the running conversion finish
			if (soft_rst || start_evt || state_d != ST_CONVERT)
				stop_pending_q <= 1'b0;
			else if (stop_evt && !single_shot)
				stop_pending_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial gain divider: 7FFFFFh * 400000h / averaged full-scale reading
	// one bit a cycle keeps area small at the cost of 46 cycles latency

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			div_num_q <= '0;
			div_rem_q <= '0;
			div_den_q <= '0;
			div_quot_q <= '0;
			div_ovf_q <= 1'b0;
			div_cnt_q <= '0;
		end
		else if (ce_i)
		begin
			if (cal_last && is_gain_cal)
			begin
				div_num_q <= {`ADCC_POS_FULL, 22'h00_0000}; // [R5]
				div_rem_q <= '0;
				// a non-positive reading forces the divider to saturate
				div_den_q <= (cal_avg[23] || cal_avg == 24'h00_0000) ? 24'h00_0001 : cal_avg;
				div_quot_q <= '0;
				div_ovf_q <= 1'b0;
				div_cnt_q <= '0;
			end
			else if (state_q == ST_DIVIDE)
			begin
				div_num_q <= {div_num_q[44:0], 1'b0};
				div_rem_q <= div_rem_n;
				div_quot_q <= {div_quot_q[22:0], div_ge};
				div_ovf_q <= div_ovf_q | div_quot_q[23];
				div_cnt_q <= 6'(div_cnt_q + 6'h01);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// conversion result, ready line and filter restart

	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			result_q <= '0;
			ready_n_q <= 1'b1;
			restart_q <= 1'b0;
		end
		else if (ce_i)
		begin
			restart_q <= !soft_rst && (start_evt || cal_ok || (cal_last && !is_gain_cal) || div_last);
			// a fresh result wins over a host read in the same cycle
			if (soft_rst || start_evt || cal_ok || state_d == ST_SLEEP)
				ready_n_q <= 1'b1; // [R26]
			else if (conv_done)
			begin
				result_q <= corr_w; // [R2] [R9]
				ready_n_q <= 1'b0; // [R9]
			end
			else if (data_read_i)
				ready_n_q <= 1'b1;
		end
	end

	// register read-back
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
			reg_rdata_q <= '0;
		else if (ce_i)
		begin
			case (reg_sel_i)
				`ADCC_SEL_OFFSET: reg_rdata_q <= offset_q;
				`ADCC_SEL_GAIN: reg_rdata_q <= gain_q;
				`ADCC_SEL_CTRL: reg_rdata_q <= 24'(ctrl_q);
				default: reg_rdata_q <= 24'(status_o);
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign reg_rdata_o = reg_rdata_q;
	assign result_o = result_q;
	assign result_ready_n_o = ready_n_q; // [R26]
	assign conv_restart_o = restart_q;
	assign conv_run_o = (state_q == ST_CONVERT) || in_cal;
	assign powered_down_o = (state_q == ST_SLEEP); // [R14]
	assign ext_clock_sel_o = ctrl_q[`ADCC_CTRL_EXTCLK]; // [R17]
	assign monitor_input_select_o = (in_cal && cal_kind_q == CAL_SELF_OFS) ?
		`ADCC_MON_MIDSCALE : `ADCC_MON_NORMAL; // [R7]
	// not-ready reads one only while internal configuration runs
	assign status_o = 8'((8'(power_on_flag_q) << `ADCC_STAT_POR) |
		(8'(state_q == ST_CONFIG) << `ADCC_STAT_NRDY)); // [R21] [R24] [R18]

endmodule // adcc_control
`default_nettype wire

// File: sim/adcc_props.sv
// assertions on the ports of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_props #(
	parameter int unsigned POR_CYCLES = 8
)
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// commands and filter
	input wire logic cmd_start_i,
	input wire logic cmd_sleep_i,
	input wire logic cmd_reset_i,
	input wire logic cmd_self_ofs_cal_i,
	input wire logic filt_valid_i,
	// observed outputs
	input wire logic conv_restart_o,
	input wire logic conv_run_o,
	input wire logic [2:0] monitor_input_select_o,
	input wire logic ext_clock_sel_o,
	input wire logic powered_down_o,
	input wire logic result_ready_n_o,
	input wire logic [7:0] status_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	// config length counter, armed only by the power-on reset
	logic [7:0] por_cnt_q;
	logic first_q;
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i || !status_o[6])
			por_cnt_q <= 8'h00;
		else
			por_cnt_q <= por_cnt_q + 8'h01;
		first_q <= !reset_n_i || (first_q && status_o[6]);
	end

	sequence s_run_up;
		conv_restart_o && conv_run_o;
	endsequence
	sequence s_idle;
		!conv_run_o && result_ready_n_o && !ext_clock_sel_o;
	endsequence
	property p_reset;
		disable iff (1'b0) !reset_n_i |=> s_idle ##0 status_o == 8'h40;
	endproperty
	a_reset: assert property (p_reset) else $error("bad state under reset");
	property p_reset_cmd;
		cmd_reset_i |=> s_idle ##0 status_o[6];
	endproperty
	a_reset_cmd: assert property (p_reset_cmd) else $error("reset command ignored");
	property p_por;
		$fell(status_o[6]) && first_q |-> por_cnt_q == 8'(POR_CYCLES + 1) && status_o[7];
	endproperty
	a_por: assert property (p_por) else $error("config length or flag wrong");
	property p_start;
		cmd_start_i && !status_o[6] && !powered_down_o && !cmd_sleep_i && !cmd_reset_i
			|=> s_run_up;
	endproperty
	a_start: assert property (p_start) else $error("start did not restart");
	property p_sleep;
		cmd_sleep_i && !status_o[6] && !cmd_reset_i |=> powered_down_o && !conv_run_o;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep did not abort");
	property p_cal_mon;
		cmd_self_ofs_cal_i && conv_run_o && !cmd_start_i && !cmd_sleep_i && !cmd_reset_i
			|=> monitor_input_select_o == 3'h1;
	endproperty
	a_cal_mon: assert property (p_cal_mon) else $error("mid-scale not selected");
	property p_standby;
		cmd_self_ofs_cal_i && !conv_run_o |=> monitor_input_select_o == 3'h0;
	endproperty
	a_standby: assert property (p_standby) else $error("calibration in standby");
	property p_cal_quiet;
		monitor_input_select_o != 3'h0 |-> result_ready_n_o;
	endproperty
	a_cal_quiet: assert property (p_cal_quiet) else $error("ready low in calibration");
	property p_ready;
		$fell(result_ready_n_o) |-> $past(filt_valid_i);
	endproperty
	a_ready: assert property (p_ready) else $error("ready fell without sample");
endmodule // adcc_props

bind adcc_control adcc_props #(.POR_CYCLES(POR_CYCLES)) adcc_props_inst (.*);
`default_nettype wire

// File: sim/adcc_filter_model.sv
// filter model: one sample every DLY+1 cycles of a running conversion
`timescale 1ns/1ps
`default_nettype none
module adcc_filter_model #(
	parameter int DLY = 6
)
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// conversion control from the block
	input wire logic restart_i,
	input wire logic run_i,
	input wire logic [23:0] level_i,
	// samples to the block
	output logic valid_o = 1'b0,
	output logic [23:0] data_o = 24'h00_0000
);
	int cnt = 0;
	// data shows the inverse outside a sample so stale values never pass
	always @(posedge mclk_i)
	begin
		valid_o <= 1'b0;
		data_o <= ~level_i;
		if (!reset_n_i || restart_i || !run_i)
			cnt <= 0;
		else if (cnt == DLY)
		begin
			cnt <= 0;
			valid_o <= 1'b1;
			data_o <= level_i;
		end
		else
			cnt <= cnt + 1;
	end
endmodule // adcc_filter_model
`default_nettype wire

// File: sim/tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic start_sync_i = 1'b0;
	logic pin_rst_n = 1'b1;
	logic [8:0] cmd = 9'h000;
	logic reg_wr_i = 1'b0;
	logic [1:0] reg_sel_i = 2'h0;
	logic [23:0] reg_wdata_i = 24'h00_0000;
	logic [23:0] level = 24'h00_0000;
	logic filt_valid_i;
	logic [23:0] filt_data_i, reg_rdata_o, result_o;
	logic conv_restart_o, conv_run_o, ext_clock_sel_o, powered_down_o, result_ready_n_o;
	logic [2:0] monitor_input_select_o;
	logic [7:0] status_o;
	int n_mismatch = 0;
	int num_checks = 0;

	// cmd bits: start stop sleep wake reset selfcal sysofs sysgain read
	adcc_control #(.POR_CYCLES(8)) adcc_control_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.ce_i(1'b1), .start_sync_i(start_sync_i), .pin_reset_n_i(pin_rst_n),
		.cmd_start_i(cmd[0]), .cmd_stop_i(cmd[1]), .cmd_sleep_i(cmd[2]), .cmd_wake_i(cmd[3]),
		.cmd_reset_i(cmd[4]), .cmd_self_ofs_cal_i(cmd[5]), .cmd_sys_ofs_cal_i(cmd[6]),
		.cmd_sys_gain_cal_i(cmd[7]), .data_read_i(cmd[8]), .status_clear_i(1'b0),
		.reg_wr_i(reg_wr_i), .reg_sel_i(reg_sel_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .filt_valid_i(filt_valid_i), .filt_data_i(filt_data_i),
		.conv_restart_o(conv_restart_o), .conv_run_o(conv_run_o),
		.monitor_input_select_o(monitor_input_select_o), .ext_clock_sel_o(ext_clock_sel_o),
		.powered_down_o(powered_down_o), .result_o(result_o),
		.result_ready_n_o(result_ready_n_o), .status_o(status_o));
	adcc_filter_model adcc_filter_model_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.restart_i(conv_restart_o), .run_i(conv_run_o), .level_i(level),
		.valid_o(filt_valid_i), .data_o(filt_data_i));

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		if (n_mismatch == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic pulse(input int b);
		@(negedge mclk_i);
		cmd[b] = 1'b1;
		@(negedge mclk_i);
		cmd[b] = 1'b0;
	endtask
	task automatic wr(input logic [1:0] s, input logic [23:0] d);
		@(negedge mclk_i);
		reg_wr_i = 1'b1;
		reg_sel_i = s;
		reg_wdata_i = d;
		@(negedge mclk_i);
		reg_wr_i = 1'b0;
	endtask
	// read data is registered, so give it two edges
	task automatic rd(input logic [1:0] s, input logic [23:0] e);
		@(negedge mclk_i);
		reg_sel_i = s;
		repeat (2) @(negedge mclk_i);
		chk(reg_rdata_o, e);
	endtask
	task automatic wait_rdy();
		int i;
		i = 0;
		repeat (2) @(negedge mclk_i);
		while (result_ready_n_o !== 1'b0 && i < 600)
		begin
			@(negedge mclk_i);
			i++;
		end
		chk({23'h0, result_ready_n_o}, 24'h00_0000);
	endtask
	task automatic wait_cfg();
		int i;
		i = 0;
		while (status_o[6] !== 1'b0 && i < 50)
		begin
			@(negedge mclk_i);
			i++;
		end
		chk({23'h0, status_o[6]}, 24'h00_0000);
	endtask
	// full precision reference, then clip
	function automatic logic [23:0] corr(input logic [23:0] s, o, g, input logic c);
		logic signed [49:0] v;
		v = $signed(s) - (c ? 50'sd0 : $signed(o));
		v = (v * $signed({1'b0, g})) >>> 22;
		if (v > 50'sd8388607)
			return 24'h7F_FFFF;
		if (v < -50'sd8388608)
			return 24'h80_0000;
		return v[23:0];
	endfunction
	function automatic logic [23:0] gcal(input logic [23:0] a);
		logic [47:0] q;
		q = {24'h7F_FFFF, 22'h0} / {24'h00_0000, a};
		return (q > 48'hFF_FFFF) ? 24'hFF_FFFF : q[23:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_por();
		wr(2'h0, 24'h00_0123);
		wait_cfg();
		chk(status_o, 24'h00_0080);
		rd(2'h0, 24'h00_0000);
		rd(2'h1, 24'h40_0000);
		rd(2'h3, 24'h00_0080);
	endtask
	task automatic t_corr();
		logic [23:0] s [5] = '{24'h00_0100, 24'h7F_FFFF, 24'h80_0000, 24'h10_0000, 24'h10_0000};
		logic [23:0] o [5] = '{24'h00_0001, 24'h80_0000, 24'h00_0001, 24'h00_0000, 24'h0F_0000};
		logic [23:0] g [5] = '{24'h40_0000, 24'h40_0000, 24'h40_0000, 24'h43_3333, 24'h3C_CCCC};
		for (int k = 0; k < 5; k++)
		begin
			wr(2'h0, o[k]);
			wr(2'h1, g[k]);
			wr(2'h2, {22'h0, k == 4, 1'b0});
			level = s[k];
			pulse(0);
			wait_rdy();
			chk(result_o, corr(s[k], o[k], g[k], k == 4));
			chk(conv_run_o, 1'b1);
		end
		pulse(8);
		chk(result_ready_n_o, 1'b1);
	endtask
	task automatic t_cal();
		wr(2'h2, 24'h00_0000);
		pulse(0);
		for (int k = 0; k < 4; k++)
		begin
			wr(2'h2, {20'h0, 2'(k), 2'b00});
			level = 24'h00_0010 * 24'(k + 1);
			pulse(5 + k % 2);
			wait_rdy();
			rd(2'h0, level);
			chk(result_o, 24'h00_0000);
		end
		level = 24'h40_0000;
		pulse(7);
		wait_rdy();
		rd(2'h1, gcal(24'h3F_FFC0));
		chk(result_o, corr(level, 24'h00_0040, gcal(24'h3F_FFC0), 1'b0));
	endtask
	task automatic t_single();
		wr(2'h2, 24'h00_0001);
		pulse(0);
		wait_rdy();
		repeat (2) @(negedge mclk_i);
		chk(conv_run_o, 1'b0);
		pulse(5);
		rd(2'h0, 24'h00_0040);
	endtask
	task automatic t_sleep();
		wr(2'h2, 24'h00_0010);
		wr(2'h0, 24'h00_0777);
		chk(ext_clock_sel_o, 1'b1);
		pulse(0);
		pulse(2);
		chk({powered_down_o, conv_run_o}, 24'h00_0002);
		pulse(3);
		chk(powered_down_o, 1'b0);
		pulse(4);
		wait_cfg();
		chk(ext_clock_sel_o, 1'b0);
		rd(2'h0, 24'h00_0000);
		chk(conv_run_o, 1'b0);
	endtask
	task automatic t_pin();
		@(negedge mclk_i);
		start_sync_i = 1'b1;
		repeat (5) @(negedge mclk_i);
		chk(conv_run_o, 1'b1);
		start_sync_i = 1'b0;
		repeat (4) @(negedge mclk_i);
		pulse(8);
		wait_rdy();
		repeat (2) @(negedge mclk_i);
		chk(conv_run_o, 1'b0);
		chk(result_o, level);
		// stop command lets the running conversion finish, then standby
		pulse(0);
		pulse(1);
		wait_rdy();
		repeat (2) @(negedge mclk_i);
		chk(conv_run_o, 1'b0);
		// reset pin: flag kept, registers back to defaults
		wr(2'h0, 24'h00_0555);
		pin_rst_n = 1'b0;
		repeat (4) @(negedge mclk_i);
		chk(status_o, 24'h00_00C0);
		pin_rst_n = 1'b1;
		wait_cfg();
		rd(2'h0, 24'h00_0000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// clock, watchdog and main sequence
	initial
	begin
		forever #10 mclk_i = ~mclk_i;
	end
	initial
	begin
		repeat (20000) @(posedge mclk_i);
		n_mismatch++;
		end_of_test();
	end
	initial
	begin
		repeat (10) @(negedge mclk_i);
		reset_n_i = 1'b1;
		t_por();
		t_corr();
		t_cal();
		t_single();
		t_sleep();
		t_pin();
		end_of_test();
	end
endmodule // tb
`default_nettype wire
